//--- hw/rx_status_pkg.sv
// receive status monitor: shared constants, register map and types
// assumes a 10 MHz system clock and a level input for the dejitter FIFO
package rx_status_pkg;

	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned LOS_TIME_NS = 1000000; // 1 msec
	// least time, rounded up to whole cycles
	localparam int unsigned LOS_CYCLES =
		(LOS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned LOS_CNT_W = 14;

	// ------------------------------------------------------------
	// register map, status page
	// ------------------------------------------------------------
	localparam logic [7:0] STATUS_PAGE = 8'h03;
	localparam logic [4:0] OFS_SLIP_PATTERN_PHASE_HIGH = 5'h15;
	localparam logic [4:0] OFS_FRAME_PHASE_LOW = 5'h16;
	localparam logic [4:0] OFS_DEJITTER_FIFO_STATUS = 5'h17;
	localparam logic [4:0] OFS_LINE_LOOP_STATUS = 5'h18;
	localparam logic [7:0] READ_DATA_RESET = 8'h00;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int unsigned BIT_SLIP_TOGGLE = 7;
	localparam int unsigned BIT_SLIP_DIRECTION = 6;
	localparam int unsigned BIT_ALT_PATTERN = 5;
	localparam int unsigned BIT_CONSEC_ERR = 4;
	localparam int unsigned BIT_CLOCK_SLOW = 7;
	localparam int unsigned BIT_CLOCK_FAST = 6;
	localparam int unsigned BIT_FIFO_EMPTY = 5;
	localparam int unsigned BIT_FIFO_FOUR_USED = 4;
	localparam int unsigned BIT_FIFO_HALF = 3;
	localparam int unsigned BIT_FIFO_FOUR_FREE = 2;
	localparam int unsigned BIT_FIFO_FULL = 1;
	localparam int unsigned BIT_HEAVY_ATTEN = 7;
	localparam int unsigned BIT_MODERATE_ATTEN = 6;
	localparam int unsigned BIT_LIGHT_ATTEN = 5;
	localparam int unsigned BIT_SIGNAL_LOST = 4;

	// ------------------------------------------------------------
	// dejitter FIFO geometry and thresholds
	// ------------------------------------------------------------
	localparam int unsigned FIFO_DEPTH = 32;
	localparam int unsigned FIFO_LVL_W = 6;
	localparam logic [5:0] FIFO_FOUR_USED = 6'h04;
	localparam logic [5:0] FIFO_HALF = 6'h10;
	localparam logic [5:0] FIFO_FOUR_FREE = 6'h1C;
	localparam logic [5:0] FIFO_FULL = 6'h20;

	// ------------------------------------------------------------
	// phase counter and alternating pattern detector
	// ------------------------------------------------------------
	localparam int unsigned PHASE_W = 12;
	localparam logic [11:0] PHASE_RESET = 12'h000;
	localparam logic [9:0] ALT_WINDOW_BITS = 10'h200; // 512 bits
	localparam logic [3:0] ALT_ERR_LIMIT = 4'h4;

	typedef enum logic [1:0] {
		ALT_HUNT = 2'b00,
		ALT_LOCK = 2'b01
	} alt_state_t;

endpackage

//--- hw/alt_pattern_detector.sv
// alternating 1010 pattern detector on the recovered line bits
// assumes line bits arrive with a one-cycle strobe on ref_clk_i
`timescale 1ns/1ps
module alt_pattern_detector (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// recovered line data
	input wire logic line_bit_i,
	input wire logic line_bit_valid_i,
	// result
	output logic alternating_pattern_seen_o
);

	rx_status_pkg::alt_state_t state_q, state_d;
	logic expect_q;
	logic [9:0] bit_cnt_q;
	logic [3:0] err_cnt_q;
	logic window_end, mismatch, window_ok;
	logic [4:0] err_sum;

	// ------------------------------------------------------------
	// window decode
	// ------------------------------------------------------------
	// expected bit keeps toggling, so one flipped bit is one mismatch
	assign mismatch = line_bit_i != expect_q;
	assign window_end = line_bit_valid_i &&
		(bit_cnt_q == rx_status_pkg::ALT_WINDOW_BITS - 10'h001);
	// a few errors per window still pass, covering 1e-3
	// sum one bit wider, so a saturated count cannot wrap into a pass
	assign err_sum = {1'b0, err_cnt_q} + {4'h0, mismatch};
	assign window_ok = err_sum <= {1'b0, rx_status_pkg::ALT_ERR_LIMIT};

	// state decision at each 512 bit window end
	always_comb begin
		state_d = state_q;
		case (state_q)
			rx_status_pkg::ALT_HUNT: begin
				if (window_end && window_ok)
					state_d = rx_status_pkg::ALT_LOCK;
			end
			rx_status_pkg::ALT_LOCK: begin
				if (window_end && !window_ok)
					state_d = rx_status_pkg::ALT_HUNT;
			end
			default: state_d = rx_status_pkg::ALT_HUNT;
		endcase
	end

	// window counters and phase tracking
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_q <= rx_status_pkg::ALT_HUNT;
			expect_q <= 1'b0;
			bit_cnt_q <= 10'h000;
			err_cnt_q <= 4'h0;
		end else if (line_bit_valid_i) begin
			state_q <= state_d;
			// resync on a failed window: next bit expected inverted
			expect_q <= (window_end && !window_ok) ? ~line_bit_i : ~expect_q;
			bit_cnt_q <= window_end ? 10'h000 : bit_cnt_q + 10'h001;
			err_cnt_q <= window_end ? 4'h0 :
				(err_cnt_q == 4'hF ? err_cnt_q : err_cnt_q + {3'h0, mismatch});
		end
	end

	assign alternating_pattern_seen_o = state_q == rx_status_pkg::ALT_LOCK;

	a_alt_hunt_low: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		window_end && !window_ok |=> !alternating_pattern_seen_o)
		else $error("pattern flag held after a failed window");

endmodule

//--- hw/frame_phase_counter.sv
// eighth-bit phase counter between backplane and receive frame pulses
// assumes eighth_bit_tick_i comes from a phase generator on ref_clk_i
`timescale 1ns/1ps
module frame_phase_counter (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// timing strobes
	input wire logic backplane_frame_pulse_i,
	input wire logic receive_frame_pulse_i,
	input wire logic eighth_bit_tick_i,
	// measured phase
	output logic [11:0] frame_phase_count_o
);

	logic [11:0] count_q;
	logic [11:0] count_now;

	// ------------------------------------------------------------
	// counting
	// ------------------------------------------------------------
	// tick landing on the same cycle as the receive pulse is counted, halving error
	assign count_now = count_q + {11'h000, eighth_bit_tick_i};

	// count from backplane pulse, latch all 12 bits at receive pulse
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			count_q <= rx_status_pkg::PHASE_RESET;
			frame_phase_count_o <= rx_status_pkg::PHASE_RESET;
		end else begin
			count_q <= backplane_frame_pulse_i ? 12'h000 : count_now;
			if (receive_frame_pulse_i)
				frame_phase_count_o <= count_now;
		end
	end

	a_phase_latch: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		receive_frame_pulse_i && !backplane_frame_pulse_i |=>
		frame_phase_count_o == $past(count_now))
		else $error("phase count not latched at receive frame pulse");

endmodule

//--- hw/rx_status_monitor.sv
// receive status monitor: slip, pattern, alignment, phase, dejitter and
// line loop status, read through the paged status registers
// assumes event strobes and FIFO level come from logic on ref_clk_i;
// analogue comparator levels arrive asynchronously from the line front end
`timescale 1ns/1ps
module rx_status_monitor #(
	parameter int unsigned LOS_CYCLES = rx_status_pkg::LOS_CYCLES
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// register access
	input wire logic cs_i,
	input wire logic rw_i,
	input wire logic [7:0] page_i,
	input wire logic [4:0] addr_i,
	output logic [7:0] rd_data_o,
	// elastic buffer slips
	input wire logic slip_event_i,
	input wire logic slip_repeat_i,
	// recovered line data
	input wire logic line_bit_i,
	input wire logic line_bit_valid_i,
	// frame alignment word checks
	input wire logic fas_valid_i,
	input wire logic fas_error_i,
	// frame timing
	input wire logic backplane_frame_pulse_i,
	input wire logic receive_frame_pulse_i,
	input wire logic eighth_bit_tick_i,
	// dejitter unit
	input wire logic dejitter_clock_slow_i,
	input wire logic dejitter_clock_fast_i,
	input wire logic [5:0] dejitter_fifo_level_i,
	// analogue front end comparators
	input wire logic heavy_attenuation_i,
	input wire logic moderate_attenuation_i,
	input wire logic light_attenuation_i,
	input wire logic amplitude_low_i
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic slip_toggle_q;
	logic slip_direction_q;
	logic last_fas_err_q;
	logic consecutive_alignment_errors_q;
	logic alternating_pattern_seen;
	logic [11:0] frame_phase_count;
	logic [11:0] phase_shadow_q;
	logic [4:0] fifo_flags_q;
	logic [1:0] dejitter_clk_q;
	logic [3:0] analog_meta_q;
	logic [3:0] analog_sync_q;
	logic [13:0] los_cnt_q;
	logic analogue_signal_lost_q;
	logic heavy_s, moderate_s, light_s, amp_low_s;
	logic rd_strobe, wr_strobe, page_hit;
	logic sel_high, sel_low, sel_fifo, sel_loop;
	logic [7:0] high_word, low_word, fifo_word, loop_word, rd_mux;
	logic [4:0] fifo_flags_d;
	logic los_expired;

	// ------------------------------------------------------------
	// FIFO threshold decode
	// ------------------------------------------------------------
	// returns {full, four_free, half, four_used, empty}
	function automatic logic [4:0] fifo_flags(input logic [5:0] level);
		logic [4:0] f;
		f = 5'h00;
		f[0] = level == 6'h00;
		f[1] = level >= rx_status_pkg::FIFO_FOUR_USED;
		f[2] = level >= rx_status_pkg::FIFO_HALF;
		f[3] = level >= rx_status_pkg::FIFO_FOUR_FREE;
		f[4] = level >= rx_status_pkg::FIFO_FULL;
		return f;
	endfunction

	assign fifo_flags_d = fifo_flags(dejitter_fifo_level_i);

	// ------------------------------------------------------------
	// submodules
	// ------------------------------------------------------------
	// alternating pattern hunt over 512 bit windows
	alt_pattern_detector u_alt (
		.ref_clk_i(ref_clk_i),
		.reset_i(reset_i),
		.line_bit_i(line_bit_i),
		.line_bit_valid_i(line_bit_valid_i),
		.alternating_pattern_seen_o(alternating_pattern_seen)
	);

	// frame phase measurement
	frame_phase_counter u_phase (
		.ref_clk_i(ref_clk_i),
		.reset_i(reset_i),
		.backplane_frame_pulse_i(backplane_frame_pulse_i),
		.receive_frame_pulse_i(receive_frame_pulse_i),
		.eighth_bit_tick_i(eighth_bit_tick_i),
		.frame_phase_count_o(frame_phase_count)
	);

	// ------------------------------------------------------------
	// slip tracking
	// ------------------------------------------------------------
	// toggle on every slip, direction only moves on a slip
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			slip_toggle_q <= 1'b0;
			slip_direction_q <= 1'b0;
		end else if (slip_event_i) begin
			slip_toggle_q <= ~slip_toggle_q;
			slip_direction_q <= slip_repeat_i;
		end
	end

	// ------------------------------------------------------------
	// frame alignment word history
	// ------------------------------------------------------------
	// flag is the AND of the last two checked words
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			last_fas_err_q <= 1'b0;
			consecutive_alignment_errors_q <= 1'b0;
		end else if (fas_valid_i) begin
			last_fas_err_q <= fas_error_i;
			consecutive_alignment_errors_q <=
				fas_error_i && last_fas_err_q;
		end
	end

	// ------------------------------------------------------------
	// dejitter unit status
	// ------------------------------------------------------------
	// same-clock levels, registered once for a clean read
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			fifo_flags_q <= 5'h01;
			dejitter_clk_q <= 2'b00;
		end else begin
			fifo_flags_q <= fifo_flags_d;
			dejitter_clk_q <= {dejitter_clock_slow_i,
				dejitter_clock_fast_i};
		end
	end

	// ------------------------------------------------------------
	// analogue comparator synchronisers
	// ------------------------------------------------------------
	// two flops per asynchronous comparator level
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			analog_meta_q <= 4'h0;
			analog_sync_q <= 4'h0;
		end else begin
			analog_meta_q <= {heavy_attenuation_i, moderate_attenuation_i,
				light_attenuation_i, amplitude_low_i};
			analog_sync_q <= analog_meta_q;
		end
	end

	assign heavy_s = analog_sync_q[3];
	assign moderate_s = analog_sync_q[2];
	assign light_s = analog_sync_q[1];
	assign amp_low_s = analog_sync_q[0];

	// ------------------------------------------------------------
	// analogue loss of signal timer
	// ------------------------------------------------------------
	assign los_expired = los_cnt_q >= LOS_CYCLES[13:0] - 14'h0001;

	// count while amplitude is low, set once 1 msec has passed
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			los_cnt_q <= 14'h0000;
			analogue_signal_lost_q <= 1'b0;
		end else if (!amp_low_s) begin
			los_cnt_q <= 14'h0000;
			analogue_signal_lost_q <= 1'b0;
		end else begin
			if (!los_expired)
				los_cnt_q <= los_cnt_q + 14'h0001;
			if (los_expired)
				analogue_signal_lost_q <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// register decode
	// ------------------------------------------------------------
	// reads only; writes decode but change nothing
	assign rd_strobe = cs_i && rw_i;
	assign wr_strobe = cs_i && !rw_i;
	assign page_hit = page_i == rx_status_pkg::STATUS_PAGE;
	assign sel_high = page_hit &&
		addr_i == rx_status_pkg::OFS_SLIP_PATTERN_PHASE_HIGH;
	assign sel_low = page_hit &&
		addr_i == rx_status_pkg::OFS_FRAME_PHASE_LOW;
	assign sel_fifo = page_hit &&
		addr_i == rx_status_pkg::OFS_DEJITTER_FIFO_STATUS;
	assign sel_loop = page_hit &&
		addr_i == rx_status_pkg::OFS_LINE_LOOP_STATUS;

	// register words, unused bits tied to zero
	assign high_word = {slip_toggle_q, slip_direction_q,
		alternating_pattern_seen, consecutive_alignment_errors_q,
		frame_phase_count[11:8]};
	assign low_word = phase_shadow_q[7:0];
	assign fifo_word = {dejitter_clk_q, fifo_flags_q[0], fifo_flags_q[1],
		fifo_flags_q[2], fifo_flags_q[3], fifo_flags_q[4], 1'b0};
	assign loop_word = {heavy_s, moderate_s, light_s,
		analogue_signal_lost_q, 4'h0};

	// read multiplexer, unmapped addresses read zero
	assign rd_mux = sel_high ? high_word :
		sel_low ? low_word :
		sel_fifo ? fifo_word :
		sel_loop ? loop_word : 8'h00;

	// ------------------------------------------------------------
	// read data and phase shadow
	// ------------------------------------------------------------
	// upper read freezes the full count for the lower read
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			rd_data_o <= rx_status_pkg::READ_DATA_RESET;
			phase_shadow_q <= rx_status_pkg::PHASE_RESET;
		end else begin
			if (rd_strobe)
				rd_data_o <= rd_mux;
			if (rd_strobe && sel_high)
				phase_shadow_q <= frame_phase_count;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_slip_toggle_flip: assert property (@(posedge ref_clk_i)
		disable iff (reset_i)
		slip_event_i |=> slip_toggle_q != $past(slip_toggle_q))
		else $error("slip toggle did not change on a slip");

	a_slip_dir_set: assert property (@(posedge ref_clk_i)
		disable iff (reset_i)
		slip_event_i && slip_repeat_i |=> slip_direction_q)
		else $error("repeated frame slip did not set direction");

	a_slip_dir_hold: assert property (@(posedge ref_clk_i)
		disable iff (reset_i)
		!slip_event_i |=> $stable(slip_direction_q) &&
		$stable(slip_toggle_q))
		else $error("slip status moved without a slip");

	a_consec_err_set: assert property (@(posedge ref_clk_i)
		disable iff (reset_i)
		fas_valid_i && fas_error_i && last_fas_err_q |=>
		consecutive_alignment_errors_q)
		else $error("two errored alignment words did not set flag");

	a_consec_err_clr: assert property (@(posedge ref_clk_i)
		disable iff (reset_i)
		fas_valid_i && !fas_error_i |=> !consecutive_alignment_errors_q)
		else $error("clean alignment word did not clear flag");

	a_clock_slow: assert property (@(posedge ref_clk_i)
		disable iff (reset_i)
		##1 dejitter_clk_q[1] == $past(dejitter_clock_slow_i))
		else $error("clock slow bit does not follow the unit");

	a_clock_fast: assert property (@(posedge ref_clk_i)
		disable iff (reset_i)
		##1 dejitter_clk_q[0] == $past(dejitter_clock_fast_i))
		else $error("clock fast bit does not follow the unit");

	a_fifo_empty: assert property (@(posedge ref_clk_i)
		disable iff (reset_i)
		dejitter_fifo_level_i == 6'h00 |=> fifo_flags_q[0])
		else $error("empty flag missing at zero level");

	a_fifo_full: assert property (@(posedge ref_clk_i)
		disable iff (reset_i)
		dejitter_fifo_level_i == 6'h1F |=> !fifo_flags_q[4])
		else $error("full flag set one short of full");

	a_fifo_four_used: assert property (@(posedge ref_clk_i)
		disable iff (reset_i)
		dejitter_fifo_level_i == 6'h03 |=> !fifo_flags_q[1])
		else $error("four used flag set at three entries");

	a_fifo_half: assert property (@(posedge ref_clk_i)
		disable iff (reset_i)
		dejitter_fifo_level_i == 6'h10 |=> fifo_flags_q[2])
		else $error("half flag missing at midpoint");

	a_fifo_four_free: assert property (@(posedge ref_clk_i)
		disable iff (reset_i)
		dejitter_fifo_level_i == 6'h1B |=> !fifo_flags_q[3])
		else $error("four free flag set with five vacant");

	a_atten_heavy: assert property (@(posedge ref_clk_i)
		disable iff (reset_i)
		heavy_attenuation_i [*3] |-> heavy_s)
		else $error("heavy attenuation not seen after sync");

	a_los_clear: assert property (@(posedge ref_clk_i)
		disable iff (reset_i)
		!amp_low_s |=> !analogue_signal_lost_q)
		else $error("signal lost flag held with amplitude normal");

	a_los_wait: assert property (@(posedge ref_clk_i)
		disable iff (reset_i)
		$rose(analogue_signal_lost_q) |->
		los_cnt_q == LOS_CYCLES[13:0] - 14'h0001)
		else $error("signal lost flag set before the timer ran out");

	a_write_ignored: assert property (@(posedge ref_clk_i)
		disable iff (reset_i)
		wr_strobe |=> $stable(rd_data_o) && $stable(phase_shadow_q))
		else $error("write changed read data");

	a_phase_coherent: assert property (@(posedge ref_clk_i)
		disable iff (reset_i)
		rd_strobe && sel_high |=> phase_shadow_q == $past(frame_phase_count)
		&& rd_data_o[3:0] == phase_shadow_q[11:8])
		else $error("phase halves not captured together");

endmodule

//--- tb/rx_status_monitor_tb.sv
// self-checking bench for the receive status monitor
// assumes the design's status page map and a 10 MHz reference clock
`timescale 1ns/1ps
module rx_status_monitor_tb;

	// ------------------------------------------------------------
	// stimulus and observation signals
	// ------------------------------------------------------------
	logic ref_clk_i, reset_i, cs_i, rw_i;
	logic [7:0] page_i;
	logic [4:0] addr_i;
	logic [7:0] rd_data_o;
	logic slip_event_i, slip_repeat_i, line_bit_i, line_bit_valid_i;
	logic fas_valid_i, fas_error_i, backplane_frame_pulse_i;
	logic receive_frame_pulse_i, eighth_bit_tick_i;
	logic dejitter_clock_slow_i, dejitter_clock_fast_i;
	logic [5:0] dejitter_fifo_level_i;
	logic heavy_attenuation_i, moderate_attenuation_i;
	logic light_attenuation_i, amplitude_low_i;
	int errors, total_checks, cycles;
	int lvl;
	logic [7:0] exp;

	rx_status_monitor #(.LOS_CYCLES(20)) i_rx_status_monitor (.*);

	// ------------------------------------------------------------
	// clock, timeout and closing report
	// ------------------------------------------------------------
	initial begin
		ref_clk_i = 1'b0;
		forever #50 ref_clk_i = ~ref_clk_i;
	end

	// cut a hang short well past the expected run length
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// access and event tasks
	// ------------------------------------------------------------
	// move to just after the n-th next rising edge
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask

	// one read access, masked compare of the answer
	task automatic rd(input logic [4:0] a, input logic [7:0] m,
		input logic [7:0] e, input string nm);
		logic [7:0] got;
		step(1);
		cs_i = 1'b1;
		rw_i = 1'b1;
		addr_i = a;
		step(1);
		cs_i = 1'b0;
		got = rd_data_o & m;
		total_checks++;
		if (got !== (e & m)) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e & m, got);
		end
	endtask

	// one write access, which must leave no trace
	task automatic wr(input logic [4:0] a);
		step(1);
		cs_i = 1'b1;
		rw_i = 1'b0;
		addr_i = a;
		step(1);
		cs_i = 1'b0;
	endtask

	task automatic slip(input logic rep);
		step(1);
		slip_event_i = 1'b1;
		slip_repeat_i = rep;
		step(1);
		slip_event_i = 1'b0;
	endtask

	task automatic fas(input logic err);
		step(1);
		fas_valid_i = 1'b1;
		fas_error_i = err;
		step(1);
		fas_valid_i = 1'b0;
	endtask

	// backplane pulse, then n eighth-bit ticks ending on the receive pulse
	task automatic phase(input int n);
		step(1);
		backplane_frame_pulse_i = 1'b1;
		step(1);
		backplane_frame_pulse_i = 1'b0;
		eighth_bit_tick_i = 1'b1;
		step(n - 1);
		receive_frame_pulse_i = 1'b1;
		step(1);
		receive_frame_pulse_i = 1'b0;
		eighth_bit_tick_i = 1'b0;
	endtask

	// n line bits, alternating with one flipped bit, or all zero
	task automatic bits(input int n, input logic alt, input int bad);
		for (int i = 0; i < n; i++) begin
			step(1);
			line_bit_valid_i = 1'b1;
			line_bit_i = alt ? (i[0] ^ (i == bad)) : 1'b0;
		end
		step(1);
		line_bit_valid_i = 1'b0;
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{cs_i, rw_i, slip_event_i, slip_repeat_i, line_bit_i} = '0;
		{line_bit_valid_i, fas_valid_i, fas_error_i} = '0;
		{backplane_frame_pulse_i, receive_frame_pulse_i} = '0;
		{eighth_bit_tick_i, dejitter_clock_slow_i} = '0;
		{dejitter_clock_fast_i, heavy_attenuation_i} = '0;
		{moderate_attenuation_i, light_attenuation_i} = '0;
		amplitude_low_i = 1'b0;
		dejitter_fifo_level_i = 6'h00;
		page_i = 8'h03;
		addr_i = 5'h00;
		errors = 0;
		total_checks = 0;
		cycles = 0;
		reset_i = 1'b1;
		step(4);
		reset_i = 1'b0;
		// reset values
		rd(5'h15, 8'hFF, 8'h00, "high after reset");
		rd(5'h17, 8'hFF, 8'h20, "fifo after reset");
		rd(5'h18, 8'hFF, 8'h00, "loop after reset");
		// slips toggle and set direction only on a slip
		slip(1'b1);
		rd(5'h15, 8'hC0, 8'hC0, "slip repeat");
		slip(1'b0);
		rd(5'h15, 8'hC0, 8'h00, "slip drop");
		step(3);
		rd(5'h15, 8'hC0, 8'h00, "slip idle");
		slip(1'b1);
		slip(1'b1);
		rd(5'h15, 8'hC0, 8'h40, "slip pair");
		// two errored alignment words in a row
		fas(1'b1);
		rd(5'h15, 8'h10, 8'h00, "one errored");
		fas(1'b1);
		rd(5'h15, 8'h10, 8'h10, "two errored");
		fas(1'b0);
		rd(5'h15, 8'h10, 8'h00, "clean word");
		fas(1'b1);
		rd(5'h15, 8'h10, 8'h00, "clean then errored");
		fas(1'b1);
		rd(5'h15, 8'h10, 8'h10, "errored again");
		// phase count, split halves and coherent snapshot
		phase(421);
		rd(5'h15, 8'h0F, 8'h01, "phase high");
		rd(5'h16, 8'hFF, 8'hA5, "phase low");
		phase(243);
		rd(5'h16, 8'hFF, 8'hA5, "phase low stale");
		rd(5'h15, 8'h0F, 8'h00, "phase high new");
		rd(5'h16, 8'hFF, 8'hF3, "phase low new");
		phase(4095);
		rd(5'h15, 8'h0F, 8'h0F, "phase high max");
		rd(5'h16, 8'hFF, 8'hFF, "phase low max");
		// dejitter flags over fill-level boundaries, writes ignored
		for (int k = 0; k < 11; k++) begin
			// last pass sits one short of full
			lvl = (k < 10) ? (k * 4) - (k % 2) : 31;
			if (lvl < 0)
				lvl = 0;
			if (lvl > 32)
				lvl = 32;
			dejitter_fifo_level_i = lvl[5:0];
			dejitter_clock_slow_i = (k % 3 == 1);
			dejitter_clock_fast_i = (k % 3 == 2);
			exp = {k % 3 == 1, k % 3 == 2, lvl == 0, lvl >= 4,
				lvl >= rx_status_pkg::FIFO_DEPTH / 2,
				rx_status_pkg::FIFO_DEPTH - lvl <= 4,
				lvl == rx_status_pkg::FIFO_DEPTH, 1'b0};
			step(1);
			wr(5'h17);
			rd(5'h17, 8'hC1, exp, "clock");
			rd(5'h17, 8'h3E, exp, "fifo");
		end
		// unmapped address and foreign page read zero
		rd(5'h10, 8'hFF, 8'h00, "unmapped");
		page_i = 8'h02;
		rd(5'h17, 8'hFF, 8'h00, "other page");
		page_i = 8'h03;
		// attenuation classes through the synchronisers
		for (int k = 0; k < 3; k++) begin
			heavy_attenuation_i = (k == 0);
			moderate_attenuation_i = (k == 1);
			light_attenuation_i = (k == 2);
			step(4);
			rd(5'h18, 8'hFF, {k == 0, k == 1, k == 2, 5'h00}, "loop");
		end
		// loss of signal only after the full hold time
		amplitude_low_i = 1'b1;
		step(10);
		rd(5'h18, 8'h10, 8'h00, "los early");
		step(30);
		rd(5'h18, 8'h10, 8'h10, "los set");
		amplitude_low_i = 1'b0;
		step(6);
		rd(5'h18, 8'h10, 8'h00, "los clear");
		// alternating pattern with one bit error, then silence
		rd(5'h15, 8'h20, 8'h00, "pattern idle");
		bits(1100, 1'b1, 700);
		rd(5'h15, 8'h20, 8'h20, "pattern seen");
		bits(1100, 1'b0, -1);
		rd(5'h15, 8'h20, 8'h00, "pattern gone");
		end_of_test();
	end

endmodule
